/* inc/hsel_regs.svh */
// register offsets, field positions and reset values of the input select bank
`ifndef HSEL_REGS_SVH
`define HSEL_REGS_SVH
`define HSEL_OFF_SELECT   4'h0
`define HSEL_OFF_CONTROL  4'h4
`define HSEL_POS_A_BIT    0
`define HSEL_NEG_A_LSB    1
`define HSEL_POS_B_BIT    8
`define HSEL_NEG_B_LSB    9
`define HSEL_CTL_12B_BIT  0
`define HSEL_CTL_ALT_BIT  1
`define HSEL_RST_SELECT   3'h0
`define HSEL_RST_CONTROL  2'h0
`define HSEL_NEG_VREF_HI  2'h2
`define HSEL_NEG_HI       2'h3
`define HSEL_AN_VREF      4'hf
`endif

/* inc/hsel_pkg.sv */
// types shared by the holder input select bank
package hsel_pkg;
  typedef struct packed {
    logic [1:0] neg_sel;
    logic       pos_sel;
  } hsel_mux_t;
  typedef struct packed {
    logic [3:0] holder_one;
    logic [3:0] holder_two;
    logic [3:0] holder_three;
  } hsel_route_t;
endpackage

/* src/hsel_bank.sv */
// holder one to three input select register with avalon-mm slave
`include "hsel_regs.svh"
`default_nettype none
module hsel_bank
  import hsel_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // front end steering
  input  wire logic        i_use_sample_b,
  output hsel_route_t      o_pos_route,
  output hsel_route_t      o_neg_route,
  output logic             o_twelve_bit_mode
);
  logic       rst_meta;
  logic       rst_sync_n;
  hsel_mux_t  sel_a;
  hsel_mux_t  sel_b;
  logic       twelve_bit_mode;
  logic       alt_pin_meta;
  logic       alt_pin;
  logic       alt_enable;
  logic       ack;
  hsel_mux_t  next_sel_a;
  hsel_mux_t  next_sel_b;
  logic       next_twelve_bit_mode;
  logic       next_alt_enable;
  logic       next_ack;
  logic [31:0] next_readdata;
  hsel_route_t next_pos_route;
  hsel_route_t next_neg_route;
  hsel_mux_t  active;

  // negative code decode; upper bit zero means reference
  function automatic logic [3:0] neg_input(input logic [1:0] code,
                                           input logic [3:0] base);
    logic [3:0] r;
    r = `HSEL_AN_VREF;
    if (code == `HSEL_NEG_HI) begin
      r = 4'h9 + base;
    end else if (code == `HSEL_NEG_VREF_HI) begin
      r = 4'h6 + base;
    end
    return r;
  endfunction

  function automatic logic [3:0] pos_input(input logic sel,
                                           input logic [3:0] base);
    return sel ? 4'h3 + base : 4'h0 + base;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // alternate select arrives from the sequencer domain, so synchronise
  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alt_pin_meta <= 1'b0;
      alt_pin      <= 1'b0;
    end else begin
      alt_pin_meta <= i_use_sample_b;
      alt_pin      <= alt_pin_meta;
    end
  end

  logic acc_sel;
  logic acc_ctl;
  assign acc_sel = i_address == `HSEL_OFF_SELECT;
  assign acc_ctl = i_address == `HSEL_OFF_CONTROL;

  always_comb begin
    next_sel_a           = sel_a;
    next_sel_b           = sel_b;
    next_twelve_bit_mode = twelve_bit_mode;
    next_alt_enable      = alt_enable;
    next_ack             = (i_read || i_write) && !ack;
    next_readdata        = o_readdata;
    if (i_write && !ack) begin
      // writes to the select fields are dropped in 12-bit mode
      if (acc_sel && !twelve_bit_mode) begin
        if (i_byteenable[0]) begin
          next_sel_a.pos_sel = i_writedata[`HSEL_POS_A_BIT];
          next_sel_a.neg_sel =
            i_writedata[`HSEL_NEG_A_LSB +: 2];
        end
        if (i_byteenable[1]) begin
          next_sel_b.pos_sel = i_writedata[`HSEL_POS_B_BIT];
          next_sel_b.neg_sel = i_writedata[`HSEL_NEG_B_LSB +: 2];
        end
      end
      if (acc_ctl && i_byteenable[0]) begin
        next_twelve_bit_mode = i_writedata[`HSEL_CTL_12B_BIT];
        next_alt_enable      = i_writedata[`HSEL_CTL_ALT_BIT];
      end
    end
    if (i_read && !ack) begin
      next_readdata = 32'h0000_0000;
      if (acc_sel && !twelve_bit_mode) begin
        next_readdata[`HSEL_POS_A_BIT]     = sel_a.pos_sel;
        next_readdata[`HSEL_NEG_A_LSB +: 2] = sel_a.neg_sel;
        next_readdata[`HSEL_POS_B_BIT]     = sel_b.pos_sel;
        next_readdata[`HSEL_NEG_B_LSB +: 2] = sel_b.neg_sel;
      end else if (acc_ctl) begin
        next_readdata[`HSEL_CTL_12B_BIT] = twelve_bit_mode;
        next_readdata[`HSEL_CTL_ALT_BIT] = alt_enable;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_a           <= hsel_mux_t'(`HSEL_RST_SELECT);
      sel_b           <= hsel_mux_t'(`HSEL_RST_SELECT);
      twelve_bit_mode <= 1'b0;
      alt_enable      <= 1'b0;
      ack             <= 1'b0;
      o_readdata      <= 32'h0000_0000;
    end else begin
      sel_a           <= next_sel_a;
      sel_b           <= next_sel_b;
      twelve_bit_mode <= next_twelve_bit_mode;
      alt_enable      <= next_alt_enable;
      ack             <= next_ack;
      o_readdata      <= next_readdata;
    end
  end

  // one wait cycle per access; answer on the second edge
  assign o_waitrequest = (i_read || i_write) && !ack;

  // alternating only when enabled, else sample a always
  always_comb begin
    active = (alt_enable && alt_pin) ? sel_b : sel_a;
    next_pos_route.holder_one   = pos_input(active.pos_sel, 4'h0);
    next_pos_route.holder_two   = pos_input(active.pos_sel, 4'h1);
    next_pos_route.holder_three = pos_input(active.pos_sel, 4'h2);
    next_neg_route.holder_one   = neg_input(active.neg_sel, 4'h0);
    next_neg_route.holder_two   = neg_input(active.neg_sel, 4'h1);
    next_neg_route.holder_three = neg_input(active.neg_sel, 4'h2);
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_pos_route <= '0;
      o_neg_route <= {3{`HSEL_AN_VREF}};
    end else begin
      o_pos_route <= next_pos_route;
      o_neg_route <= next_neg_route;
    end
  end

  assign o_twelve_bit_mode = twelve_bit_mode;

  neg_code_hi_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    active.neg_sel == 2'h3 |=> o_neg_route.holder_one == 4'h9 &&
      o_neg_route.holder_three == 4'hb)
    else $error("negative code 11 misrouted");
  neg_code_mid_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    active.neg_sel == 2'h2 |=> o_neg_route.holder_two == 4'h7)
    else $error("negative code 10 misrouted");
  neg_vref_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    !active.neg_sel[1] |=> o_neg_route.holder_one == `HSEL_AN_VREF)
    else $error("negative reference not selected");
  pos_high_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    active.pos_sel |=> o_pos_route.holder_three == 4'h5)
    else $error("positive set misrouted");
  pos_low_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    !active.pos_sel |=> o_pos_route.holder_two == 4'h1)
    else $error("positive clear misrouted");
  neg_locked_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    twelve_bit_mode |=> $stable(sel_a.neg_sel) && $stable(sel_b.neg_sel))
    else $error("negative field changed in 12-bit mode");
  sel_read_zero_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    i_read && !ack && acc_sel && twelve_bit_mode |=> o_readdata == 0)
    else $error("select read not zero in 12-bit mode");
  upper_zero_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    i_read && !ack && acc_sel |=> o_readdata[7:3] == 5'h00)
    else $error("unimplemented bits read nonzero");
  sample_b_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    alt_enable && alt_pin |-> active == sel_b)
    else $error("sample b not in use");

  // bus handshake steps: a fresh request, then the answering cycle
  sequence bus_req_s;
    (i_read || i_write) && !ack;
  endsequence

  sequence bus_ans_s;
    ack && !o_waitrequest;
  endsequence

  sequence sel_write_s;
    i_write && !ack && acc_sel && !twelve_bit_mode;
  endsequence

  sequence sel_read_s;
    i_read && !ack && acc_sel;
  endsequence

  // exactly one wait cycle, so masters never stall longer
  wait_one_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    bus_req_s |=> bus_ans_s)
    else $error("answer not on the second edge");

  neg_code_hi_two_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    active.neg_sel == 2'h3 |=> o_neg_route.holder_two == 4'ha)
    else $error("negative code 11 misrouted on holder two");

  neg_code_mid_ends_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    active.neg_sel == 2'h2 |=> o_neg_route.holder_one == 4'h6 &&
      o_neg_route.holder_three == 4'h8)
    else $error("negative code 10 misrouted");

  neg_vref_all_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    !active.neg_sel[1] |=> o_neg_route.holder_two == `HSEL_AN_VREF &&
      o_neg_route.holder_three == `HSEL_AN_VREF)
    else $error("negative reference missing on holder two or three");

  pos_high_ends_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    active.pos_sel |=> o_pos_route.holder_one == 4'h3 &&
      o_pos_route.holder_two == 4'h4)
    else $error("positive set misrouted");

  pos_low_ends_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    !active.pos_sel |=> o_pos_route.holder_one == 4'h0 &&
      o_pos_route.holder_three == 4'h2)
    else $error("positive clear misrouted");

  pos_locked_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    twelve_bit_mode |=> $stable(sel_a.pos_sel) && $stable(sel_b.pos_sel))
    else $error("positive bit changed in 12-bit mode");

  neg_read_zero_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    sel_read_s ##0 twelve_bit_mode |=> o_readdata[10:9] == 2'h0 &&
      o_readdata[2:1] == 2'h0)
    else $error("negative field read not zero in 12-bit mode");

  sel_b_write_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    sel_write_s ##0 i_byteenable[1] |=>
      sel_b.neg_sel == $past(i_writedata[10:9]) &&
      sel_b.pos_sel == $past(i_writedata[8]))
    else $error("sample b field not written");

  sel_a_write_a: assert property (@(posedge i_clk)
    disable iff (!rst_sync_n)
    sel_write_s ##0 i_byteenable[0] |=>
      sel_a.neg_sel == $past(i_writedata[2:1]) &&
      sel_a.pos_sel == $past(i_writedata[0]))
    else $error("sample a field not written");

  high_zero_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    sel_read_s |=> o_readdata[31:11] == 21'h0 &&
      o_readdata[7:3] == 5'h00)
    else $error("select read shows unimplemented bits");

  sample_a_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    !(alt_enable && alt_pin) |-> active == sel_a)
    else $error("sample a not in use");

  // read data must stand until the next read is taken
  read_hold_a: assert property (@(posedge i_clk) disable iff (!rst_sync_n)
    !(i_read && !ack) |=> $stable(o_readdata))
    else $error("read data moved without a read");
endmodule
`default_nettype wire

/* test/hsel_bank_bench.sv */
// self-checking bench for the holder input select register bank
`default_nettype none
module hsel_bank_bench
  import hsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk;
  logic        i_rst_n;
  logic [3:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [3:0]  i_byteenable;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        i_use_sample_b;
  hsel_route_t o_pos_route;
  hsel_route_t o_neg_route;
  logic        o_twelve_bit_mode;
  logic [31:0] rd;
  int          bad_count;
  int          checks_done;
  // {select bits, expected pos route, expected neg route}
  logic [26:0] rows [8] = '{{3'h0, 24'h012fff}, {3'h1, 24'h345fff},
    {3'h2, 24'h012fff}, {3'h3, 24'h345fff}, {3'h4, 24'h012678},
    {3'h5, 24'h345678}, {3'h6, 24'h0129ab}, {3'h7, 24'h3459ab}};

  hsel_bank dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_use_sample_b(i_use_sample_b),
    .o_pos_route(o_pos_route), .o_neg_route(o_neg_route),
    .o_twelve_bit_mode(o_twelve_bit_mode));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, want);
    end
  endtask

  // request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      $display("ERROR %0t bus answer never came", $time);
      print_verdict();
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic route(input logic [23:0] want);
    repeat (6) @(posedge i_clk);
    chk(32'({o_pos_route, o_neg_route}), 32'(want));
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_address = 4'h0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    i_byteenable = 4'hf;
    i_use_sample_b = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    route(24'h012fff);
    $display("reset values done");
    foreach (rows[i]) begin
      bus(1'b1, 4'h0, 32'(rows[i][26:24]));
      route(rows[i][23:0]);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'(rows[i][26:24]));
    end
    $display("sample a table done");
    bus(1'b1, 4'h0, 32'hffff_ff71);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0000_0701);
    i_use_sample_b <= 1'b1;
    route(24'h345fff);
    bus(1'b1, 4'h4, 32'h2);
    route(24'h3459ab);
    i_use_sample_b <= 1'b0;
    route(24'h345fff);
    $display("sample b done");
    bus(1'b1, 4'h4, 32'h1);
    chk(32'(o_twelve_bit_mode), 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h0000_0604);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0000_0701);
    $display("twelve bit mode done");
    bus(1'b1, 4'h8, 32'hffff_ffff);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0000_0701);
    $display("unmapped address done");
    print_verdict();
  end
endmodule
`default_nettype wire
